// >>> design/ahbp_params.svh
// Constants for the asynchronous host bus port.
// Included by the package and the port module; definitions only.
`ifndef AHBP_PARAMS_SVH
`define AHBP_PARAMS_SVH
`define AHBP_ADDR_W 7
`define AHBP_DATA_W 8
`define AHBP_ADDR_RST 7'h00
`define AHBP_DATA_RST 8'h00
`define AHBP_PIN_IDLE 6'h1C
`define AHBP_STYLE_LATCH 1'b0
`define AHBP_STYLE_STROBE 1'b1
`define AHBP_RW_READ 1'b1
`define AHBP_RW_WRITE 1'b0
`endif

// >>> design/ahbp_pkg.sv
// Types for the asynchronous host bus port.
// Assumes the params header is on the include path.
`include "ahbp_params.svh"
package ahbp_pkg;
	typedef logic [`AHBP_ADDR_W-1:0] ahbp_addr_t;
	typedef logic [`AHBP_DATA_W-1:0] ahbp_data_t;
	typedef enum logic [1:0] {AHBP_IDLE, AHBP_ADDR, AHBP_ACCESS} ahbp_state_e;
	// Register-side request toward the configuration registers
	typedef struct packed {
		logic wr;
		logic rd;
		ahbp_addr_t addr;
		ahbp_data_t wdata;
	} ahbp_req_s;
endpackage

// >>> design/ahbp_port.sv
// Asynchronous parallel host port: host pins in, register access strobes out.
// Assumes all host pins are asynchronous to CLOCK; register read data is same-domain.
// Assumes the host holds every pin level for at least three clocks.
// Strobe edges are seen three clocks late: two synchroniser stages plus the output register.
//
// Contract
// - Latch style: high address latch marks cycle start and captures the address.
// - Latch style: address taken at the falling edge of the latch line.
// - Latch style: address input buffers open while the latch line is high.
// - Strobe style: latch line is active-low address strobe, low opens address buffers.
// - Access works with address strobe and chip select tied together.
// - Latch style: while read strobe low, drive addressed register onto data bus.
// - On read strobe release, stop driving data bus.
// - Strobe style: read strobe pin serves as active-low data strobe.
// - Strobe style: read/write level at data strobe fall chooses read(1) or write(0).
// - Port has a 7-bit address input and 8-bit bidirectional data bus.
`timescale 1ns/1ns
`include "ahbp_params.svh"
module ahbp_port
	import ahbp_pkg::*;
#(
	// Bus widths; the register-side struct fixes what is served
	parameter int ADDR_W = `AHBP_ADDR_W,
	parameter int DATA_W = `AHBP_DATA_W
)
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESETN,
	// Host bus pins
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic ADDR_LATCH_STROBE,
	input wire logic CS_N,
	input wire logic READ_OR_DATA_STROBE,
	input wire logic WRITE_OR_RW,
	input wire logic HOST_TYPE_SELECT,
	input wire logic HOST_TYPE_SELECT_HI,
	input wire logic [DATA_W-1:0] DATA_IN,
	output logic [DATA_W-1:0] DATA_OUT,
	output logic DATA_OE,
	// Register side
	output ahbp_req_s REG_REQ,
	input wire logic [DATA_W-1:0] REG_RDATA
);
	// Pin vector layout: single-bit pins at the bottom, data then address above
	localparam int B_HI = 0;
	localparam int B_STYLE = 1;
	localparam int B_WRW = 2;
	localparam int B_RDS = 3;
	localparam int B_CS = 4;
	localparam int B_ALS = 5;
	localparam int B_DATA = 6;
	localparam int B_ADDR = B_DATA + DATA_W;
	localparam int SW = B_ADDR + ADDR_W;
	// Idle pin levels, so leaving reset shows no false strobe or select
	localparam logic [SW-1:0] SYNC_IDLE = {{(ADDR_W + DATA_W){1'b0}}, `AHBP_PIN_IDLE};

	// Widths must match the register-side struct carried in the package
	if (ADDR_W != $bits(ahbp_addr_t) || DATA_W != $bits(ahbp_data_t)) begin : g_width_check
		$error("ahbp_port: bus widths differ from the package types");
	end

	// Two-flop synchronisers for every host pin; only the second stage is read
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	wire [SW-1:0] pins = {ADDR, DATA_IN, ADDR_LATCH_STROBE, CS_N, READ_OR_DATA_STROBE,
		WRITE_OR_RW, HOST_TYPE_SELECT, HOST_TYPE_SELECT_HI};
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
		end else begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end

	// Synchronised pin views
	wire ahbp_addr_t s_addr = sync2[B_ADDR +: ADDR_W];
	wire ahbp_data_t s_data = sync2[B_DATA +: DATA_W];
	wire s_als = sync2[B_ALS];
	wire s_cs_n = sync2[B_CS];
	wire s_rds = sync2[B_RDS];
	wire s_wrw = sync2[B_WRW];
	wire s_style = sync2[B_STYLE];
	wire s_sel_hi = sync2[B_HI];

	// Previous levels for edge detection
	logic p_als;
	logic p_rds;
	logic p_wrw;
	logic p_cs_n;
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			p_als <= 1'b0;
			p_rds <= 1'b1;
			p_wrw <= 1'b1;
			p_cs_n <= 1'b1;
		end else begin
			p_als <= s_als;
			p_rds <= s_rds;
			p_wrw <= s_wrw;
			p_cs_n <= s_cs_n;
		end
	end

	// Style decode; a high second select is unsupported and blocks access
	wire style_ok = !s_sel_hi;
	wire strobe_style = (s_style == `AHBP_STYLE_STROBE);
	wire selected = !s_cs_n && style_ok;
	// Address buffers open: latch high, or address strobe low
	wire addr_open = strobe_style ? !s_als : s_als;
	wire als_fall = p_als && !s_als;
	wire as_fall = p_als && !s_als;
	// Tied strobe and select: both fall together, address taken on the same edge
	wire addr_take = strobe_style ? as_fall : als_fall;
	// Data strobe edges
	wire ds_fall = p_rds && !s_rds;
	wire ds_rise = !p_rds && s_rds;
	// Latch style write strobe edge (data latched on release)
	wire wr_rise = !p_wrw && s_wrw;
	wire rd_active = strobe_style ? (!s_rds && s_wrw == `AHBP_RW_READ) : !s_rds;

	// Address register
	ahbp_addr_t addr;
	ahbp_addr_t next_addr;
	// Latch style follows the pins while the latch is open and freezes at its fall
	wire addr_follow = addr_open && !strobe_style;
	assign next_addr = (addr_take || addr_follow) ? s_addr : addr;
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			addr <= `AHBP_ADDR_RST;
		end else begin
			addr <= next_addr;
		end
	end

	// Operation choice at data strobe fall in strobe style
	logic op_read;
	wire next_op_read = ds_fall ? (s_wrw == `AHBP_RW_READ) : op_read;
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			op_read <= 1'b0;
		end else begin
			op_read <= next_op_read;
		end
	end

	// Cycle boundaries seen by the state machine; latch writes open on the write strobe
	wire as_held = strobe_style && !s_als && !p_cs_n;
	wire access_start = selected && (!s_rds || (!strobe_style && !s_wrw));
	wire access_end = s_rds && (strobe_style || s_wrw);
	wire as_release = strobe_style && s_als;
	// Cycle state: idle, address phase, access phase
	ahbp_state_e state;
	ahbp_state_e next_state;
	always_comb begin
		next_state = state;
		case (state)
			AHBP_IDLE: begin
				if (addr_take || as_held) begin
					next_state = AHBP_ADDR;
				end
			end
			AHBP_ADDR: begin
				if (access_start) begin
					next_state = AHBP_ACCESS;
				end else if (as_release) begin
					next_state = AHBP_IDLE;
				end
			end
			AHBP_ACCESS: begin
				if (access_end) begin
					next_state = strobe_style && !s_als ? AHBP_ADDR : AHBP_IDLE;
				end
			end
			default: next_state = AHBP_IDLE;
		endcase
	end
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			state <= AHBP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Read drive and write pulses; a write needs an access phase behind it
	wire drive = selected && rd_active;
	wire in_access = (state == AHBP_ACCESS);
	wire strobe_wr_edge = ds_rise && !op_read;
	wire latch_wr_edge = wr_rise;
	wire wr_pulse = selected && in_access && (strobe_style ? strobe_wr_edge : latch_wr_edge);
	wire rd_pulse = selected && (strobe_style ? (ds_fall && s_wrw) : ds_fall);
	wire ahbp_addr_t req_addr = addr_take ? s_addr : addr;
	wire ahbp_data_t next_data_out = drive ? REG_RDATA : `AHBP_DATA_RST;

	// Data bus drive, registered so the pins never see a decode glitch
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			DATA_OUT <= `AHBP_DATA_RST;
			DATA_OE <= 1'b0;
		end else begin
			DATA_OUT <= next_data_out;
			DATA_OE <= drive;
		end
	end

	// Register-side request: one-cycle pulses with the held address
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			REG_REQ <= '0;
		end else begin
			REG_REQ.wr <= wr_pulse;
			REG_REQ.rd <= rd_pulse;
			REG_REQ.addr <= req_addr;
			REG_REQ.wdata <= s_data;
		end
	end
endmodule

// >>> dv/ahbp_regs.sv
// Register file model behind the port
// Assumes one-cycle write pulses
`timescale 1ns/1ns
module ahbp_regs
	import ahbp_pkg::*;
(
	input wire logic CLOCK,
	input wire ahbp_req_s REG_REQ,
	output ahbp_data_t REG_RDATA
);
	ahbp_data_t mem [128];
	// Combinational read, write on pulse
	assign REG_RDATA = mem[REG_REQ.addr];
	always @(posedge CLOCK) if (REG_REQ.wr) mem[REG_REQ.addr] <= REG_REQ.wdata;
endmodule

// >>> dv/ahbp_port_assertions.sv
// Port pin checks
// Assumes bind onto ahbp_port
`timescale 1ns/1ns
module ahbp_chk
	import ahbp_pkg::*;
(
	// Watched ports
	input wire logic CLOCK, RESETN, CS_N, READ_OR_DATA_STROBE, HOST_TYPE_SELECT_HI, DATA_OE,
	input wire logic [7:0] DATA_OUT, REG_RDATA,
	input wire ahbp_req_s REG_REQ
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	// Drive and pulses follow pins
	property p_cs; DATA_OE |-> !$past(CS_N, 3); endproperty
	a_cs: assert property (p_cs) else $error("drive unselected");
	property p_wr; REG_REQ.wr |-> !$past(CS_N, 3) && !$past(HOST_TYPE_SELECT_HI, 3); endproperty
	a_wr: assert property (p_wr) else $error("bad write");
	property p_on; $rose(DATA_OE) |-> !$past(READ_OR_DATA_STROBE, 3); endproperty
	a_on: assert property (p_on) else $error("no strobe");
	property p_off; $fell(DATA_OE) |-> $past(READ_OR_DATA_STROBE, 3); endproperty
	a_off: assert property (p_off) else $error("early release");
	property p_dat; DATA_OE && $past(DATA_OE) |-> DATA_OUT == $past(REG_RDATA); endproperty
	a_dat: assert property (p_dat) else $error("wrong data");
	property p_rd; REG_REQ.rd |=> !REG_REQ.rd; endproperty
	a_rd: assert property (p_rd) else $error("long read");
	property p_wp; REG_REQ.wr |-> !REG_REQ.rd ##1 !REG_REQ.wr; endproperty
	a_wp: assert property (p_wp) else $error("long write");
	property p_adr; DATA_OE [*2] |-> $stable(REG_REQ.addr); endproperty
	a_adr: assert property (p_adr) else $error("address moved");
	// Main scenarios
	c_oe: cover property ($rose(DATA_OE));
	c_wr: cover property (REG_REQ.wr);
	c_rd: cover property (REG_REQ.rd);
endmodule
bind ahbp_port ahbp_chk u_ahbp_chk (.*);

// >>> dv/ahbp_port_tb.sv
// Bench for the host port
// Assumes model and checker compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("unexpected %0t %h", $time, a); end end
module ahbp_port_tb;
	import ahbp_pkg::*;
	logic CLOCK = 0, RESETN = 0, ale = 0, cs = 1, rds = 1, wrw = 1, hts = 0, hi = 0, oe, oe_d = 0;
	ahbp_data_t din = 8'h00, dout, rdat;
	ahbp_addr_t adr = 7'h00, ra;
	ahbp_req_s req;
	logic [15:0] q[$], got, exp;
	logic [31:0] rnd = 32'h4887;
	int miscompares = 0, total_checks = 0, cyc = 0;
	always #4 CLOCK = ~CLOCK;
	ahbp_port u_ahbp_port (.CLOCK, .RESETN, .ADDR(adr), .ADDR_LATCH_STROBE(ale), .CS_N(cs),
		.READ_OR_DATA_STROBE(rds), .WRITE_OR_RW(wrw), .HOST_TYPE_SELECT(hts), .HOST_TYPE_SELECT_HI(hi),
		.DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .REG_REQ(req), .REG_RDATA(rdat));
	ahbp_regs u_ahbp_regs (.CLOCK, .REG_REQ(req), .REG_RDATA(rdat));
	function logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task w; repeat (6) @(posedge CLOCK); endtask
	task give_verdict;
		$display("checks %0d bad %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Host cycle: s style, r read, c {hi, cs_n}; address first, then strobe tied to select
	task acc(input logic s, r, input logic [1:0] c, input ahbp_addr_t a, input ahbp_data_t d);
		if (c == 2'h0) q.push_back({r, a, d});
		hts <= s; adr <= a; ale <= 1'b1; hi <= c[1]; wrw <= s ? r : 1'b1; w;
		ale <= 1'b0; cs <= c[0]; din <= d; w;
		adr <= ~a; if (r | s) rds <= 1'b0; else wrw <= 1'b0; w;
		rds <= 1'b1; wrw <= s ? r : 1'b1; w;
		ale <= s; cs <= 1'b1; hi <= 1'b0; din <= ~d; w;
	endtask
	// Result watcher
	always @(posedge CLOCK) begin
		oe_d <= oe;
		if (req.wr || (oe && !oe_d)) begin
			got = req.wr ? {1'b0, req.addr, req.wdata} : {1'b1, req.addr, dout};
			exp = q.size() ? q.pop_front() : 'x;
			`CHK(got, exp)
		end
		if (++cyc == 5000) begin miscompares++; give_verdict; end
	end
	initial begin
		repeat (20) @(posedge CLOCK);
		RESETN <= 1'b1; w;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			ra = i ? rnd[6:0] : 7'h7F;
			acc(i[0], 1'b0, 2'h0, ra, rnd[15:8]);
			acc(i[0], 1'b1, 2'h0, ra, rnd[15:8]);
			acc(i[0], 1'b0, i[1] ? 2'h1 : 2'h2, ra, ~rnd[15:8]);
			acc(i[0], 1'b1, 2'h0, ra, rnd[15:8]);
			$display("test %0d done", i);
		end
		w;
		`CHK(q.size(), 0)
		give_verdict;
	end
endmodule
